// file: dofs_pkg.sv
// Package for the digital output function selector.
// Assumes one control clock; condition inputs synchronous except the overload and hardware enable pins.
package dofs_pkg;
    localparam int NUM_OUT    = 2;
    localparam int MODE_W     = 5;
    localparam int POS_W      = 32;
    localparam int VEL_W      = 32;
    localparam int PARAM_W    = 32;
    localparam int PLS_W      = 8;
    localparam int SYNC_STAGES = 2;

    localparam logic [MODE_W-1:0] MODE_USER      = 5'h00;
    localparam logic [MODE_W-1:0] MODE_MAINS     = 5'h01;
    localparam logic [MODE_W-1:0] MODE_SWLIMIT   = 5'h02;
    localparam logic [MODE_W-1:0] MODE_MOVEDONE  = 5'h03;
    localparam logic [MODE_W-1:0] MODE_POSERR    = 5'h04;
    localparam logic [MODE_W-1:0] MODE_POS_GT    = 5'h05;
    localparam logic [MODE_W-1:0] MODE_POS_LT    = 5'h06;
    localparam logic [MODE_W-1:0] MODE_WARNING   = 5'h07;
    localparam logic [MODE_W-1:0] MODE_ENABLE    = 5'h08;
    localparam logic [MODE_W-1:0] MODE_RESERVED  = 5'h09;
    localparam logic [MODE_W-1:0] MODE_BRAKE     = 5'h0A;
    localparam logic [MODE_W-1:0] MODE_FAULT     = 5'h0B;
    localparam logic [MODE_W-1:0] MODE_VEL_GT    = 5'h0C;
    localparam logic [MODE_W-1:0] MODE_VEL_LT    = 5'h0D;
    localparam logic [MODE_W-1:0] MODE_HOMED     = 5'h0E;
    localparam logic [MODE_W-1:0] MODE_PLS       = 5'h0F;
    localparam logic [MODE_W-1:0] MODE_CMDBUF    = 5'h10;
    localparam logic [MODE_W-1:0] MODE_INPOS     = 5'h11;
    localparam logic [MODE_W-1:0] MODE_ZPULSE    = 5'h13;
    localparam logic [MODE_W-1:0] MODE_NO_CSTOP  = 5'h14;
    localparam logic [MODE_W-1:0] MODE_PSTAGE_OK = 5'h15;

    localparam logic [1:0] OPMODE_POSITION = 2'h2;
    localparam logic [1:0] CMDSRC_SERVICE  = 2'h0;
    localparam logic       LEVEL_RESET     = 1'b0;
endpackage

// file: dofs_cond_if.sv
// Shared drive conditions passed from top to each output channel.
// Assumes all members are synchronous to clk_sys.
`timescale 1ns/1ns
interface dofs_cond_if;
    import dofs_pkg::*;
    logic                    mains_ok;
    logic                    swlim_hit;
    logic                    move_done;
    logic                    in_window;
    logic                    enabled;
    logic signed [POS_W-1:0] pos_err;
    logic signed [POS_W-1:0] position;
    logic                    warning;
    logic                    brake_released;
    logic                    fault;
    logic        [VEL_W-1:0] abs_vel;
    logic                    homed_ok;
    logic        [PLS_W-1:0] pls_flags;
    logic                    cmdbuf_busy;
    logic                    zpulse;
    logic                    cstop_active;
    logic                    pstage_ok;
    modport src
    (
        output mains_ok, swlim_hit, move_done, in_window, enabled, pos_err,
        position, warning, brake_released, fault, abs_vel, homed_ok,
        pls_flags, cmdbuf_busy, zpulse, cstop_active, pstage_ok
    );
    modport snk
    (
        input mains_ok, swlim_hit, move_done, in_window, enabled, pos_err,
        position, warning, brake_released, fault, abs_vel, homed_ok,
        pls_flags, cmdbuf_busy, zpulse, cstop_active, pstage_ok
    );
endinterface

// file: dofs_channel.sv
// One output channel: function mux, overload latch-off, output register.
// Assumes synchronous reset copy and synchronised overload sense.
`timescale 1ns/1ns
module dofs_channel
    import dofs_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    dofs_cond_if.snk                       cond,
    input  wire logic        [MODE_W-1:0]  mode,
    input  wire logic signed [PARAM_W-1:0] param,
    input  wire logic                      user_level,
    input  wire logic                      overload,
    output logic                           pin_out,
    output logic                           readback
);
    logic                    level_next;
    logic                    trip_reg;
    logic signed [POS_W-1:0] err_abs;
    logic                    was_on_reg;

    always_comb
    begin
        err_abs = cond.pos_err[POS_W-1] ? -cond.pos_err : cond.pos_err;
    end

    always_comb
    begin
        level_next = 1'b0;
        unique case (mode)
            MODE_USER:      level_next = user_level;                      // R1
            MODE_MAINS:     level_next = cond.mains_ok;                   // R3
            MODE_SWLIMIT:   level_next = cond.swlim_hit;                  // R4
            MODE_MOVEDONE:  level_next = cond.move_done && cond.in_window; // R5
            MODE_INPOS:     level_next = cond.in_window;                  // R6
            MODE_POSERR:    level_next = cond.enabled && (err_abs < param); // R7
            MODE_POS_GT:    level_next = cond.position > param;           // R8
            MODE_POS_LT:    level_next = cond.position < param;           // R8
            MODE_WARNING:   level_next = cond.warning;                    // R9
            MODE_ENABLE:    level_next = cond.enabled;                    // R10
            MODE_BRAKE:     level_next = cond.brake_released;             // R11
            MODE_FAULT:     level_next = cond.fault;                      // R12
            MODE_VEL_GT:    level_next = cond.abs_vel > param;            // R13
            MODE_VEL_LT:    level_next = cond.abs_vel < param;            // R13
            MODE_HOMED:     level_next = cond.homed_ok;                   // R14
            MODE_PLS:       level_next = |(cond.pls_flags
                                           & param[PLS_W-1:0]);           // R15
            MODE_CMDBUF:    level_next = cond.cmdbuf_busy;                // R16
            MODE_ZPULSE:    level_next = cond.zpulse;                     // R17
            MODE_NO_CSTOP:  level_next = !cond.cstop_active;              // R18
            MODE_PSTAGE_OK: level_next = cond.pstage_ok;                  // R19
            default:        level_next = 1'b0;                            // R10
        endcase
    end

    // Latch-off only releases once the function asks for off
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            trip_reg <= 1'b0;
        else if (overload && pin_out)
            trip_reg <= 1'b1;                                             // R2
        else if (!level_next && !overload)
            trip_reg <= 1'b0;                                             // R2
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pin_out <= LEVEL_RESET;                                       // R20
        else
            pin_out <= level_next && !trip_reg && !overload;              // R2
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            readback <= LEVEL_RESET;
        else
            readback <= (mode == MODE_ZPULSE) ? 1'b0 : level_next
                        && !trip_reg && !overload;                        // R17
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            was_on_reg <= 1'b0;
        else
            was_on_reg <= pin_out;
    end

    trip_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trip_reg |=> !pin_out) else $error("output on while tripped"); // R2
    zread_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(mode) == MODE_ZPULSE |-> !readback)
        else $error("readback not zero in z mode");                   // R17
    user_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_USER && !overload && !trip_reg) |=>
        pin_out == $past(user_level)) else $error("user level lost"); // R1
    reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == MODE_RESERVED |=> !pin_out)
        else $error("reserved mode drove output");                    // R10
    overload_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        overload |=> !pin_out) else $error("on during overload");      // R2
endmodule

// file: dofs_top.sv
// Digital output function selector for a servo drive.
// Assumes conditions come from drive control logic on clk_sys, while
// overload senses and hardware enable arrive from pins.
//
// Contract
// (R1) Mode 0 drives the user or fieldbus written level.
// (R2) Overload trips output off; held off until turned off, not on.
// (R3) Mode 1 high while bus voltage between under and over levels.
// (R4) Mode 2 asserts when a software limit is reached toward it.
// (R5) Mode 3 asserts after trajectory done and position within window.
// (R6) Mode 17 asserts as soon as position is within window; the code also requires task_queued low.
// (R7) Mode 4 high when enabled and following error magnitude below param.
// (R8) Mode 5 position above param; mode 6 position below param.
// (R9) Mode 7 asserts on any warning, limit switches included.
// (R10) Mode 8 asserts while enabled; mode 9 reserved, output low.
// (R11) Mode 10 high while brake released, low while applied.
// (R12) Mode 11 high while a drive fault is present.
// (R13) Mode 12 speed above param; mode 13 speed below param.
// (R14) Mode 14 high after homing done, position opmode, service source.
// (R15) Mode 15 high when any limit switch flag under mask is set.
// (R16) Mode 16 high while a command buffer executes.
// (R17) Mode 19 copies index pulse; readback always zero.
// (R18) Mode 20 high unless a controlled stop is active.
// (R19) Mode 21 low on power stage fault or low hardware enable.
// (R20) Every output evaluated and registered each cycle; low after reset.
`timescale 1ns/1ns
module dofs_top
    import dofs_pkg::*;
(
    input  wire logic                                 clk_sys,
    input  wire logic                                 rstn,
    input  wire logic [NUM_OUT-1:0][MODE_W-1:0]       output_mode,
    input  wire logic [NUM_OUT-1:0][PARAM_W-1:0]      output_function_parameter,
    input  wire logic [NUM_OUT-1:0]                   user_level,
    input  wire logic [NUM_OUT-1:0]                   overload_pin,
    input  wire logic                                 hw_enable_pin,
    input  wire logic                                 bus_above_uv,
    input  wire logic                                 bus_below_ov,
    input  wire logic signed [POS_W-1:0]              position,
    input  wire logic signed [POS_W-1:0]              sw_limit_neg,
    input  wire logic signed [POS_W-1:0]              sw_limit_pos,
    input  wire logic                                 moving_neg,
    input  wire logic                                 moving_pos,
    input  wire logic                                 traj_zero,
    input  wire logic                                 task_queued,
    input  wire logic signed [POS_W-1:0]              target_position,
    input  wire logic        [POS_W-1:0]              target_position_window,
    input  wire logic                                 drive_enabled,
    input  wire logic signed [POS_W-1:0]              position_following_error,
    input  wire logic                                 warning_any,
    input  wire logic                                 limit_switch_pos,
    input  wire logic                                 limit_switch_neg,
    input  wire logic                                 brake_released,
    input  wire logic                                 fault_any,
    input  wire logic signed [VEL_W-1:0]              velocity,
    input  wire logic                                 homing_done,
    input  wire logic        [1:0]                    opmode,
    input  wire logic        [1:0]                    cmd_source,
    input  wire logic        [PLS_W-1:0]              limit_switch_unit_flags,
    input  wire logic                                 cmd_buffer_busy,
    input  wire logic                                 encoder_emulation_output,
    input  wire logic                                 controlled_stop_active,
    input  wire logic                                 power_stage_fault,
    output logic             [NUM_OUT-1:0]            output_pin,
    output logic             [NUM_OUT-1:0]            output_level_readback
);
    logic [SYNC_STAGES-1:0]   rst_sync_reg;
    logic                     rst_n;
    logic [NUM_OUT-1:0]       ovl_meta_reg;
    logic [NUM_OUT-1:0]       ovl_reg;
    logic                     hwen_meta_reg;
    logic                     hwen_reg;
    logic signed [POS_W-1:0]  pos_diff;
    logic signed [POS_W-1:0]  pos_dist;

    dofs_cond_if cond ();

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rst_sync_reg <= '0;
        else
            rst_sync_reg <= {rst_sync_reg[SYNC_STAGES-2:0], 1'b1};
    end
    assign rst_n = rst_sync_reg[SYNC_STAGES-1];

    // Pin senses are asynchronous to the control clock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovl_meta_reg  <= '0;
            ovl_reg       <= '0;
            hwen_meta_reg <= 1'b0;
            hwen_reg      <= 1'b0;
        end
        else
        begin
            ovl_meta_reg  <= overload_pin;
            ovl_reg       <= ovl_meta_reg;
            hwen_meta_reg <= hw_enable_pin;
            hwen_reg      <= hwen_meta_reg;
        end
    end

    always_comb
    begin
        pos_diff = position - target_position;
        pos_dist = pos_diff[POS_W-1] ? -pos_diff : pos_diff;
    end

    assign cond.mains_ok  = bus_above_uv && bus_below_ov;                 // R3
    assign cond.swlim_hit = (moving_neg && position <= sw_limit_neg)
                         || (moving_pos && position >= sw_limit_pos);     // R4
    assign cond.move_done = traj_zero && !task_queued;                    // R5
    assign cond.in_window = !task_queued
                         && ($unsigned(pos_dist) <= target_position_window); // R6
    assign cond.enabled   = drive_enabled;
    assign cond.pos_err   = position_following_error;
    assign cond.position  = position;
    assign cond.warning   = warning_any || limit_switch_pos
                         || limit_switch_neg;                             // R9
    assign cond.brake_released = brake_released;
    assign cond.fault     = fault_any;
    // Most negative velocity still yields its true magnitude, as abs_vel is unsigned
    assign cond.abs_vel   = velocity[VEL_W-1] ? $unsigned(-velocity)
                                              : $unsigned(velocity);      // R13
    assign cond.homed_ok  = homing_done && opmode == OPMODE_POSITION
                         && cmd_source == CMDSRC_SERVICE;                 // R14
    assign cond.pls_flags = limit_switch_unit_flags;
    assign cond.cmdbuf_busy = cmd_buffer_busy;
    assign cond.zpulse    = encoder_emulation_output;
    assign cond.cstop_active = controlled_stop_active;
    assign cond.pstage_ok = !power_stage_fault && hwen_reg;               // R19

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_ch
            dofs_channel u_ch
            (
                .clk_sys  (clk_sys),
                .rst_n    (rst_n),
                .cond     (cond.snk),
                .mode     (output_mode[gi]),
                .param    (output_function_parameter[gi]),
                .user_level (user_level[gi]),
                .overload (ovl_reg[gi]),
                .pin_out  (output_pin[gi]),
                .readback (output_level_readback[gi])
            );
        end
    endgenerate

    reset_low_a: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> output_pin == '0)
        else $error("outputs not low after reset");                   // R20
    pstage_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_mode[0] == MODE_PSTAGE_OK && power_stage_fault)
        |=> !output_pin[0]) else $error("output high on stage fault"); // R19
    cstop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (output_mode[0] == MODE_NO_CSTOP && controlled_stop_active)
        |=> !output_pin[0]) else $error("high during stop");           // R18
endmodule

// file: dofs_load_model.sv
// External 24 V loads on the output terminals.
// Assumes a heavy load only draws overload current while it is driven.
`timescale 1ns/1ns
module dofs_load_model
    import dofs_pkg::*;
(
    input  wire logic [NUM_OUT-1:0] output_pin,
    input  wire logic [NUM_OUT-1:0] heavy_load,
    output logic      [NUM_OUT-1:0] overload_pin
);
    // Undriven terminal draws no current, so the sense drops with the pin
    assign overload_pin = output_pin & heavy_load;
endmodule

// file: dofs_tb.sv
// Self-checking bench for the digital output function selector.
// Assumes the package constants and the load model beside it.
`timescale 1ns/1ns
module tb;
    import dofs_pkg::*;
    localparam int MAX_CYCLES = 4000;
    logic                            clk_sys = 1'b0;
    logic                            rstn = 1'b0;
    logic [NUM_OUT-1:0][MODE_W-1:0]  mode = '0;
    logic [NUM_OUT-1:0][PARAM_W-1:0] prm = '0;
    logic [NUM_OUT-1:0]              user_level = '0;
    logic [NUM_OUT-1:0]              heavy_load = '0;
    logic [NUM_OUT-1:0]              overload_pin;
    logic [NUM_OUT-1:0]              output_pin;
    logic [NUM_OUT-1:0]              output_level_readback;
    logic [NUM_OUT-1:0]              exp_pin = '0;
    logic [NUM_OUT-1:0]              exp_rb = '0;
    logic [NUM_OUT-1:0]              skip = '0;
    logic                            hw_en = 1'b0;
    logic                            h1 = 1'b0;
    logic                            h2 = 1'b0;
    logic [16:0]                     bits = '0;
    logic signed [POS_W-1:0]         pos = '0, lneg = '0, lpos = '0;
    logic signed [POS_W-1:0]         tgt = '0, perr = '0, vel = '0;
    logic [POS_W-1:0]                win = '0;
    logic [1:0]                      opm = '0, csrc = '0;
    logic [PLS_W-1:0]                flags = '0;
    int                              errors = 0;
    int                              n_compared = 0;
    int                              cycles = 0;
    int                              settle = 0;
    int                              seed = 32'h83af_deca;

    always #10 clk_sys = ~clk_sys;

    dofs_load_model LOAD (.output_pin(output_pin), .heavy_load(heavy_load),
        .overload_pin(overload_pin));

    dofs_top DUT (.clk_sys(clk_sys), .rstn(rstn), .output_mode(mode),
        .output_function_parameter(prm), .user_level(user_level),
        .overload_pin(overload_pin), .hw_enable_pin(hw_en),
        .bus_above_uv(bits[0]), .bus_below_ov(bits[1]), .position(pos),
        .sw_limit_neg(lneg), .sw_limit_pos(lpos), .moving_neg(bits[2]),
        .moving_pos(bits[3]), .traj_zero(bits[4]), .task_queued(bits[5]),
        .target_position(tgt), .target_position_window(win),
        .drive_enabled(bits[6]), .position_following_error(perr),
        .warning_any(bits[7]), .limit_switch_pos(bits[8]),
        .limit_switch_neg(bits[9]), .brake_released(bits[10]),
        .fault_any(bits[11]), .velocity(vel), .homing_done(bits[12]),
        .opmode(opm), .cmd_source(csrc), .limit_switch_unit_flags(flags),
        .cmd_buffer_busy(bits[13]), .encoder_emulation_output(bits[14]),
        .controlled_stop_active(bits[15]), .power_stage_fault(bits[16]),
        .output_pin(output_pin),
        .output_level_readback(output_level_readback));

    // Reference level of one channel from the present inputs
    function automatic logic model(int ch);
        longint a;
        longint e;
        longint v;
        longint q;
        logic   w;
        q = prm[ch];
        a = pos - tgt;
        e = perr;
        v = vel;
        if (a < 0) a = -a;
        if (e < 0) e = -e;
        if (v < 0) v = -v;
        w = (a <= win) && !bits[5];
        case (mode[ch])
            MODE_USER:      return user_level[ch];
            MODE_MAINS:     return bits[0] && bits[1];
            MODE_SWLIMIT:   return (pos <= lneg && bits[2]) ||
                                   (pos >= lpos && bits[3]);
            MODE_MOVEDONE:  return w && bits[4];
            MODE_POSERR:    return bits[6] && e < q;
            MODE_POS_GT:    return pos > q;
            MODE_POS_LT:    return pos < q;
            MODE_WARNING:   return bits[7] || bits[8] || bits[9];
            MODE_ENABLE:    return bits[6];
            MODE_BRAKE:     return bits[10];
            MODE_FAULT:     return bits[11];
            MODE_VEL_GT:    return v > q;
            MODE_VEL_LT:    return v < q;
            MODE_HOMED:     return bits[12] && opm == OPMODE_POSITION &&
                                   csrc == CMDSRC_SERVICE;
            MODE_PLS:       return |(flags & prm[ch][PLS_W-1:0]);
            MODE_CMDBUF:    return bits[13];
            MODE_INPOS:     return w;
            MODE_ZPULSE:    return bits[14];
            MODE_NO_CSTOP:  return !bits[15];
            MODE_PSTAGE_OK: return !bits[16] && h2;
            default:        return 1'b0;
        endcase
    endfunction

    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d, n_compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        for (int c = 0; c < NUM_OUT; c++)
        begin
            exp_pin[c] = model(c);
            exp_rb[c] = exp_pin[c] && mode[c] != MODE_ZPULSE;
        end
        // Hardware enable reaches the function through two sync stages
        h2 = rstn ? h1 : 1'b0;
        h1 = rstn ? hw_en : 1'b0;
        settle = !rstn ? 0 : (settle < 9 ? settle + 1 : settle);
        cycles++;
        if (cycles >= MAX_CYCLES)
        begin
            errors++;
            $display("ERROR %0t: run did not finish in time", $time);
            complete_run();
        end
    end

    // Outputs are settled half a cycle after the evaluating edge
    always @(negedge clk_sys)
        if (rstn && settle > 6)
            for (int c = 0; c < NUM_OUT; c++)
                if (!skip[c])
                begin
                    check_bit(output_pin[c], exp_pin[c], "pin");
                    check_bit(output_level_readback[c], exp_rb[c], "rdbk");
                end

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic step;
        tick();
        bits = 17'($random(seed));
        pos = 32'($random(seed) % 64);
        lneg = 32'($random(seed) % 64);
        lpos = 32'($random(seed) % 64);
        tgt = pos + 32'($random(seed) % 12);
        win = 32'($random(seed) & 15);
        perr = 32'($random(seed) % 64);
        vel = 32'($random(seed) % 64);
        flags = 8'($random(seed));
        user_level = 2'($random(seed));
        hw_en = 1'($random(seed));
        opm = ($random(seed) & 1) ? OPMODE_POSITION : 2'h1;
        csrc = ($random(seed) & 1) ? CMDSRC_SERVICE : 2'h1;
        // Non-negative thresholds keep signed and unsigned readings equal
        for (int c = 0; c < NUM_OUT; c++)
            prm[c] = 32'($random(seed) & 63);
    endtask

    task automatic reset_phase;
        #1 rstn = 1'b0;
        repeat (3) @(negedge clk_sys);
        for (int c = 0; c < NUM_OUT; c++)
            check_bit(output_pin[c], LEVEL_RESET, "reset");
        tick();
        rstn = 1'b1;
    endtask

    initial
    begin
        repeat (7) @(posedge clk_sys);
        reset_phase();
        for (int m = 0; m < 22; m++)
        begin
            mode[0] = 5'(m);
            mode[1] = 5'((m + 11) % 22);
            repeat (40) step();
        end
        // Overload trip and latch on channel 1, channel 0 still compared
        skip[1] = 1'b1;
        mode[1] = MODE_USER;
        user_level[1] = 1'b1;
        repeat (4) tick();
        check_bit(output_pin[1], 1'b1, "pre-trip");
        heavy_load[1] = 1'b1;
        for (int i = 0; i < 8 && output_pin[1] !== 1'b0; i++) tick();
        check_bit(output_pin[1], 1'b0, "trip");
        heavy_load[1] = 1'b0;
        repeat (6) tick();
        check_bit(output_pin[1], 1'b0, "latched");
        user_level[1] = 1'b0;
        repeat (4) tick();
        user_level[1] = 1'b1;
        for (int i = 0; i < 8 && output_pin[1] !== 1'b1; i++) tick();
        check_bit(output_pin[1], 1'b1, "re-enable");
        skip[1] = 1'b0;
        reset_phase();
        mode[0] = MODE_PSTAGE_OK;
        mode[1] = MODE_ZPULSE;
        repeat (40) step();
        complete_run();
    end
endmodule
